// file: common/cod_params.svh
// Constant definitions for the configuration option decoder.
`ifndef COD_PARAMS_SVH
`define COD_PARAMS_SVH

// ==========================================================================
// Word geometry and reset values
`define COD_WORD_W 13
`define COD_NUM_WORDS 3
`define COD_W0_RSVD_MASK 13'h1c00
`define COD_W1_RSVD_MASK 13'h1800
`define COD_W2_RSVD_MASK 13'h0000
`define COD_W0_DEFAULT 13'h1fff
`define COD_W1_DEFAULT 13'h1fff
`define COD_W2_DEFAULT 13'h1fff

// ==========================================================================
// Field positions of option word 0
`define COD_W0_TYPE 9
`define COD_W0_PERIOD 8
`define COD_W0_WDTB 7
`define COD_W0_OSC_HI 6
`define COD_W0_OSC_LO 4
`define COD_W0_POWER 3
`define COD_W0_PROT_HI 2

// ==========================================================================
// Field positions of option word 1
`define COD_W1_CLK_OUT 10
`define COD_W1_PULSE 9
`define COD_W1_FILTER 8
`define COD_W1_WDT_PERIOD 7
`define COD_W1_BRANCH 6
`define COD_W1_TRIM_HI 5
`define COD_W1_TRIM_LO 2
`define COD_W1_FREQ_HI 1

// ==========================================================================
// Oscillator codes and derived values
`define COD_OSC_LOW_XTAL 3'h6
`define COD_OSC_HIGH_XTAL 3'h7
`define COD_OSC_INT_RC_HI 2'h1
`define COD_OSC_EXT_RC_HI 2'h0
`define COD_TRIM_AUTO 4'hf
`define COD_RC_KHZ_4M 14'h0fa0
`define COD_RC_KHZ_8M 14'h1f40
`define COD_RC_KHZ_1M 14'h03e8
`define COD_RC_KHZ_455K 14'h01c7
`define COD_PULSE_SHORT 6'h08
`define COD_PULSE_LONG 6'h20
`define COD_PERIODS_TWO 3'h2
`define COD_PERIODS_FOUR 3'h4
`define COD_PC_CYC_ONE 2'h1
`define COD_PC_CYC_TWO 2'h2

// ==========================================================================
// Timing
`define COD_CLK_MHZ 250
`define COD_WDT_LONG_MS 18
`define COD_WDT_SHORT_US 4500

`endif

// file: common/cod_pkg.sv
// Types shared by the configuration option decoder.
package cod_pkg;

	// ======================================================================
	// Loader states
	typedef enum logic [6:0] {
		COD_S_IDLE = 7'b0000001,
		COD_S_W0 = 7'b0000010,
		COD_S_W1 = 7'b0000100,
		COD_S_W2 = 7'b0001000,
		COD_S_W3 = 7'b0010000,
		COD_S_DEC = 7'b0100000,
		COD_S_DONE = 7'b1000000
	} cod_state_t;

	typedef logic [12:0] cod_word_t;

endpackage : cod_pkg

// file: verilog/cod_word_latch.sv
// One option word held in a register, with reserved bits forced high.
`timescale 1ns/1ns
`include "cod_params.svh"

module cod_word_latch #(
	parameter cod_pkg::cod_word_t RSVD_MASK = 13'h0000,
	parameter cod_pkg::cod_word_t RESET_VAL = 13'h1fff
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Load side
	input wire logic load,
	input wire cod_pkg::cod_word_t din,
	// Held word
	output cod_pkg::cod_word_t dout
);
	import cod_pkg::*;

	cod_word_t word_reg;
	cod_word_t word_next;

	always_comb begin
		word_next = word_reg;
		if (load) begin
			word_next = din | RSVD_MASK;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			word_reg <= RESET_VAL | RSVD_MASK;
		end else begin
			word_reg <= word_next;
		end
	end

	assign dout = word_reg;

endmodule : cod_word_latch

// file: verilog/cod_option_decoder.sv
// Loader and decoder of the one-time-programmable option words.
//
// Overview of operation
// - Two option words plus one ID word, 13 bits.
// - Word 0 bits 12..10 always read one.
// - Word 0 bit 8: two or four periods.
// - Word 0 bit 7 low enables watchdog.
// - Word 0 bits 6..4 select oscillator source.
// - RC modes: oscillator bit 0 picks pin use.
// - Crystal modes dedicate both oscillator pins.
// - Internal RC frees port 5 bit 5 pin.
// - Word 0 bit 3 selects power level.
// - Zero protect bits enable read-out protection.
// - Word 1 bits 12..11 always read one.
// - RC modes with oscillator bit 0 set: bit 10 open drain or clock.
// - Word 1 bit 9: 8 or 32 pulse.
// - Word 1 bit 8 enables glitch filter.
// - Filter bypassed in low crystal or sleep.
// - Word 1 bit 7: 18 or 4.5 ms.
// - Word 1 bit 6: one or two cycles.
// - Word 1 bits 1..0 pick RC frequency.
// - Word 2 is a customer ID field.
// - Program counter writes take selected cycles.
// - Word 0 bit 9 selects package variant.
`timescale 1ns/1ns
`include "cod_params.svh"

module cod_option_decoder #(
	parameter int unsigned WDT_LONG_CYC = `COD_WDT_LONG_MS * 1000 * `COD_CLK_MHZ,
	parameter int unsigned WDT_SHORT_CYC = `COD_WDT_SHORT_US * `COD_CLK_MHZ
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Option storage read port
	output logic [1:0] otp_addr,
	output logic otp_rd,
	input wire cod_pkg::cod_word_t otp_data,
	// Core status
	input wire logic sleep_mode,
	// Loader status and word read-back
	output logic config_done,
	output cod_pkg::cod_word_t word0_out,
	output cod_pkg::cod_word_t word1_out,
	output cod_pkg::cod_word_t customer_code,
	// Word 0 settings
	output logic package_20pin,
	output logic [2:0] instr_osc_periods,
	output logic watchdog_enable,
	output logic external_rc_mode,
	output logic internal_rc_mode,
	output logic low_freq_crystal_mode,
	output logic high_freq_crystal_mode,
	output logic port7_bit0_gpio,
	output logic port5_bit5_gpio,
	output logic osc_pins_dedicated,
	output logic power_level_sel,
	output logic code_protect,
	// Word 1 settings
	output logic osc_out_open_drain,
	output logic osc_out_instr_clk,
	output logic [5:0] filter_pulse_len,
	output logic glitch_filter_active,
	output logic [22:0] wdt_timeout_cycles,
	output logic [1:0] pc_write_cycles,
	output logic rc_trim_auto,
	output logic [13:0] rc_freq_khz
);
	import cod_pkg::*;

	// ======================================================================
	// Decode helpers
	function automatic logic osc_is_rc(input logic [2:0] osc);
		osc_is_rc = (osc[2:1] == `COD_OSC_EXT_RC_HI) || (osc[2:1] == `COD_OSC_INT_RC_HI);
	endfunction : osc_is_rc

	function automatic logic osc_is_high_xtal(input logic [2:0] osc);
		// Codes 100 and 101 have no defined mode, so they fall back to the default.
		osc_is_high_xtal = osc[2] && (osc != `COD_OSC_LOW_XTAL);
	endfunction : osc_is_high_xtal

	// ======================================================================
	// Loader sequence
	cod_state_t state_reg;
	cod_state_t state_next;
	logic [1:0] otp_addr_reg;
	logic [1:0] otp_addr_next;
	logic otp_rd_reg;
	logic otp_rd_next;
	logic done_reg;
	logic done_next;
	logic [2:0] load_word;

	// The storage answers one cycle after a read request, so each word is
	// captured one state after its address was presented.
	always_comb begin
		state_next = state_reg;
		otp_addr_next = otp_addr_reg;
		otp_rd_next = 1'b0;
		done_next = done_reg;
		case (state_reg)
			COD_S_IDLE: begin
				state_next = COD_S_W0;
				otp_rd_next = 1'b1;
				otp_addr_next = 2'h0;
			end
			COD_S_W0: begin
				state_next = COD_S_W1;
				otp_rd_next = 1'b1;
				otp_addr_next = 2'h1;
			end
			COD_S_W1: begin
				state_next = COD_S_W2;
				otp_rd_next = 1'b1;
				otp_addr_next = 2'h2;
			end
			COD_S_W2: begin
				state_next = COD_S_W3;
			end
			COD_S_W3: begin
				state_next = COD_S_DEC;
			end
			COD_S_DEC: begin
				state_next = COD_S_DONE;
				done_next = 1'b1;
			end
			COD_S_DONE: begin
				// Settings stay frozen until the next reset.
				state_next = COD_S_DONE;
			end
			default: begin
				state_next = COD_S_IDLE;
				done_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= COD_S_IDLE;
			otp_addr_reg <= 2'h0;
			otp_rd_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			otp_addr_reg <= otp_addr_next;
			otp_rd_reg <= otp_rd_next;
			done_reg <= done_next;
		end
	end

	assign load_word = {state_reg == COD_S_W3, state_reg == COD_S_W2, state_reg == COD_S_W1};

	// ======================================================================
	// Word storage, kept apart from program memory
	localparam cod_word_t RSVD [3] = '{`COD_W0_RSVD_MASK, `COD_W1_RSVD_MASK, `COD_W2_RSVD_MASK};
	localparam cod_word_t RSTV [3] = '{`COD_W0_DEFAULT, `COD_W1_DEFAULT, `COD_W2_DEFAULT};
	cod_word_t words [3];

	for (genvar gi = 0; gi < `COD_NUM_WORDS; gi++) begin : g_word
		cod_word_latch #(
			.RSVD_MASK(RSVD[gi]),
			.RESET_VAL(RSTV[gi])
		) u_word (
			.clk(clk),
			.nrst(nrst),
			.load(load_word[gi]),
			.din(otp_data),
			.dout(words[gi])
		);
	end

	// ======================================================================
	// Decoded settings
	logic [2:0] osc;
	logic is_rc;
	logic is_low_xtal;
	logic is_high_xtal;
	logic [35:0] dec_next;
	logic [35:0] dec_reg;
	logic filt_next;
	logic filt_reg;
	logic [22:0] wdt_next;
	logic [22:0] wdt_reg;
	logic [13:0] freq_next;
	logic [13:0] freq_reg;

	assign osc = words[0][`COD_W0_OSC_HI:`COD_W0_OSC_LO];
	assign is_rc = osc_is_rc(osc);
	assign is_high_xtal = osc_is_high_xtal(osc);
	assign is_low_xtal = (osc == `COD_OSC_LOW_XTAL);

	always_comb begin
		dec_next = dec_reg;
		wdt_next = wdt_reg;
		freq_next = freq_reg;
		if (state_reg == COD_S_DEC) begin
			dec_next[0] = ~words[0][`COD_W0_TYPE];
			dec_next[3:1] = words[0][`COD_W0_PERIOD] ? `COD_PERIODS_FOUR : `COD_PERIODS_TWO;
			dec_next[4] = ~words[0][`COD_W0_WDTB];
			dec_next[5] = (osc[2:1] == `COD_OSC_EXT_RC_HI);
			dec_next[6] = (osc[2:1] == `COD_OSC_INT_RC_HI);
			dec_next[7] = is_low_xtal;
			dec_next[8] = is_high_xtal;
			dec_next[9] = is_rc && !osc[0];
			dec_next[10] = (osc[2:1] == `COD_OSC_INT_RC_HI);
			dec_next[11] = !is_rc;
			dec_next[12] = words[0][`COD_W0_POWER];
			dec_next[13] = ~&words[0][`COD_W0_PROT_HI:0];
			dec_next[14] = is_rc && osc[0] && !words[1][`COD_W1_CLK_OUT];
			dec_next[15] = is_rc && osc[0] && words[1][`COD_W1_CLK_OUT];
			dec_next[21:16] = words[1][`COD_W1_PULSE] ? `COD_PULSE_LONG : `COD_PULSE_SHORT;
			dec_next[23:22] = words[1][`COD_W1_BRANCH] ? `COD_PC_CYC_TWO : `COD_PC_CYC_ONE;
			// A trim other than all ones is a programming fault and is only reported.
			dec_next[24] = (words[1][`COD_W1_TRIM_HI:`COD_W1_TRIM_LO] == `COD_TRIM_AUTO);
			dec_next[25] = words[1][`COD_W1_FILTER];
			dec_next[35:26] = 10'h000;
			wdt_next = words[1][`COD_W1_WDT_PERIOD] ? 23'(WDT_LONG_CYC) : 23'(WDT_SHORT_CYC);
			case (words[1][`COD_W1_FREQ_HI:0])
				2'h3: freq_next = `COD_RC_KHZ_4M;
				2'h2: freq_next = `COD_RC_KHZ_8M;
				2'h1: freq_next = `COD_RC_KHZ_1M;
				default: freq_next = `COD_RC_KHZ_455K;
			endcase
		end
	end

	// Sleep can change at any time, so the filter gate is refreshed every cycle.
	always_comb begin
		filt_next = done_reg && dec_reg[25] && !dec_reg[7] && !sleep_mode;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dec_reg <= 36'h000000000;
			wdt_reg <= 23'h000000;
			freq_reg <= 14'h0000;
			filt_reg <= 1'b0;
		end else begin
			dec_reg <= dec_next;
			wdt_reg <= wdt_next;
			freq_reg <= freq_next;
			filt_reg <= filt_next;
		end
	end

	// ======================================================================
	// Outputs, all straight from flip-flops
	assign otp_addr = otp_addr_reg;
	assign otp_rd = otp_rd_reg;
	assign config_done = done_reg;
	assign word0_out = words[0];
	assign word1_out = words[1];
	assign customer_code = words[2];
	assign package_20pin = dec_reg[0];
	assign instr_osc_periods = dec_reg[3:1];
	assign watchdog_enable = dec_reg[4];
	assign external_rc_mode = dec_reg[5];
	assign internal_rc_mode = dec_reg[6];
	assign low_freq_crystal_mode = dec_reg[7];
	assign high_freq_crystal_mode = dec_reg[8];
	assign port7_bit0_gpio = dec_reg[9];
	assign port5_bit5_gpio = dec_reg[10];
	assign osc_pins_dedicated = dec_reg[11];
	assign power_level_sel = dec_reg[12];
	assign code_protect = dec_reg[13];
	assign osc_out_open_drain = dec_reg[14];
	assign osc_out_instr_clk = dec_reg[15];
	assign filter_pulse_len = dec_reg[21:16];
	assign pc_write_cycles = dec_reg[23:22];
	assign rc_trim_auto = dec_reg[24];
	assign glitch_filter_active = filt_reg;
	assign wdt_timeout_cycles = wdt_reg;
	assign rc_freq_khz = freq_reg;

	// ======================================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	AST_LOAD_TIME: assert property ((state_reg == COD_S_IDLE) |-> ##6 done_reg)
		else $error("load did not finish in six cycles");
	AST_RSVD0: assert property (done_reg |-> word0_out[12:10] == 3'h7)
		else $error("word 0 reserved bits not one");
	AST_RSVD1: assert property (done_reg |-> word1_out[12:11] == 2'h3)
		else $error("word 1 reserved bits not one");
	AST_PERIOD: assert property (done_reg |->
		instr_osc_periods == (word0_out[8] ? 3'h4 : 3'h2))
		else $error("instruction period mismatch");
	AST_WDT_EN: assert property (done_reg |-> watchdog_enable != word0_out[7])
		else $error("watchdog enable mismatch");
	AST_XTAL_PINS: assert property (done_reg && word0_out[6:5] == 2'h3 |->
		osc_pins_dedicated && !port7_bit0_gpio && !port5_bit5_gpio)
		else $error("crystal pins not dedicated");
	AST_IRC_PIN: assert property (done_reg |->
		port5_bit5_gpio == (word0_out[6:5] == 2'h1))
		else $error("port 5 bit 5 release mismatch");
	AST_FILTER: assert property (done_reg && (low_freq_crystal_mode || sleep_mode) |=>
		!glitch_filter_active)
		else $error("filter active in bypass condition");
	AST_PC_CYC: assert property (done_reg |->
		pc_write_cycles == (word1_out[6] ? 2'h2 : 2'h1))
		else $error("branch cycle count mismatch");
	AST_UNDOC: assert property (done_reg && word0_out[6:5] == 2'h2 |->
		high_freq_crystal_mode && !low_freq_crystal_mode)
		else $error("undefined code not high crystal");
	AST_HOLD: assert property (done_reg |=> done_reg && $stable(word0_out)
		&& $stable(customer_code) && $stable(rc_freq_khz))
		else $error("settings changed after load");

	COV_IRC: cover property (done_reg && internal_rc_mode && osc_out_instr_clk);
	COV_LXT: cover property (done_reg && low_freq_crystal_mode);
	COV_SLEEP: cover property (done_reg && filt_reg ##1 sleep_mode ##1 !filt_reg);

endmodule : cod_option_decoder

// file: tb/cod_otp_model.sv
// Behavioural option storage holding three programmed words.
`timescale 1ns/1ns
module cod_otp_model (
	// Clock
	input wire logic clk,
	// Programmed contents
	input wire cod_pkg::cod_word_t w0,
	input wire cod_pkg::cod_word_t w1,
	input wire cod_pkg::cod_word_t w2,
	// Read port
	input wire logic [1:0] otp_addr,
	input wire logic otp_rd,
	output cod_pkg::cod_word_t otp_data
);
	import cod_pkg::*;
	// Outside a read the lines flip every cycle, so a mistimed sample shows.
	initial otp_data = 13'h0000;
	always @(posedge clk) begin
		if (otp_rd) begin
			case (otp_addr)
				2'h0: otp_data <= w0;
				2'h1: otp_data <= w1;
				default: otp_data <= w2;
			endcase
		end else begin
			otp_data <= ~otp_data;
		end
	end
endmodule : cod_otp_model

// file: tb/tb_top.sv
// Self-checking bench for the option word loader and decoder.
`timescale 1ns/1ns
module tb_top;
	import cod_pkg::*;
	localparam int unsigned WL = 40;
	localparam int unsigned WS = 10;
	// ======================================================================
	// Signals
	logic clk, nrst, sleep_mode, otp_rd, config_done;
	logic [1:0] otp_addr;
	cod_word_t w0, w1, w2, otp_data, word0_out, word1_out, customer_code;
	logic package_20pin, watchdog_enable, external_rc_mode, internal_rc_mode;
	logic low_freq_crystal_mode, high_freq_crystal_mode, port7_bit0_gpio;
	logic port5_bit5_gpio, osc_pins_dedicated, power_level_sel, code_protect;
	logic osc_out_open_drain, osc_out_instr_clk, glitch_filter_active, rc_trim_auto;
	logic [2:0] instr_osc_periods;
	logic [5:0] filter_pulse_len;
	logic [22:0] wdt_timeout_cycles;
	logic [1:0] pc_write_cycles;
	logic [13:0] rc_freq_khz;
	int n_mismatch = 0;
	int tests_run = 0;
	int k;

	cod_option_decoder #(.WDT_LONG_CYC(WL), .WDT_SHORT_CYC(WS)) cod_option_decoder_i (
		.clk(clk), .nrst(nrst), .otp_addr(otp_addr), .otp_rd(otp_rd),
		.otp_data(otp_data), .sleep_mode(sleep_mode), .config_done(config_done),
		.word0_out(word0_out), .word1_out(word1_out), .customer_code(customer_code),
		.package_20pin(package_20pin), .instr_osc_periods(instr_osc_periods),
		.watchdog_enable(watchdog_enable), .external_rc_mode(external_rc_mode),
		.internal_rc_mode(internal_rc_mode),
		.low_freq_crystal_mode(low_freq_crystal_mode),
		.high_freq_crystal_mode(high_freq_crystal_mode),
		.port7_bit0_gpio(port7_bit0_gpio), .port5_bit5_gpio(port5_bit5_gpio),
		.osc_pins_dedicated(osc_pins_dedicated), .power_level_sel(power_level_sel),
		.code_protect(code_protect), .osc_out_open_drain(osc_out_open_drain),
		.osc_out_instr_clk(osc_out_instr_clk), .filter_pulse_len(filter_pulse_len),
		.glitch_filter_active(glitch_filter_active),
		.wdt_timeout_cycles(wdt_timeout_cycles), .pc_write_cycles(pc_write_cycles),
		.rc_trim_auto(rc_trim_auto), .rc_freq_khz(rc_freq_khz)
	);

	cod_otp_model cod_otp_model_i (
		.clk(clk), .w0(w0), .w1(w1), .w2(w2),
		.otp_addr(otp_addr), .otp_rd(otp_rd), .otp_data(otp_data)
	);

	// ======================================================================
	// Clock and watchdog
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// The whole run needs well under 300 cycles.
	initial begin
		#8000;
		n_mismatch++;
		$display("watchdog expired");
		end_sim();
	end

	// ======================================================================
	// Tasks
	task automatic chk_bit(input string name, input logic exp, input logic got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %b seen %b", name, exp, got);
		end
	endtask : chk_bit

	task automatic chk_val(input string name, input logic [22:0] exp, input logic [22:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : chk_val

	task automatic load(input cod_word_t a, input cod_word_t b, input cod_word_t c);
		int i;
		w0 = a;
		w1 = b;
		w2 = c;
		nrst = 1'b0;
		repeat (3) @(negedge clk);
		chk_bit("config_done_rst", 1'b0, config_done);
		chk_val("word0_rst", 13'h1fff, word0_out);
		nrst = 1'b1;
		for (i = 0; i < 3; i++) begin
			@(negedge clk);
			chk_bit("otp_rd", 1'b1, otp_rd);
			chk_val("otp_addr", i[1:0], otp_addr);
		end
		@(negedge clk);
		chk_bit("otp_rd_end", 1'b0, otp_rd);
		i = 0;
		while (config_done !== 1'b1 && i < 20) begin
			@(negedge clk);
			i++;
		end
		chk_bit("config_done", 1'b1, config_done);
		// The filter gate is registered behind config_done, so it settles a clock later.
		@(negedge clk);
	endtask : load

	task automatic check_all();
		logic [2:0] o;
		logic rc, slow_xt;
		o = w0[6:4];
		rc = ~o[2];
		slow_xt = (o == 3'h6);
		chk_val("word0", w0 | 13'h1c00, word0_out);
		chk_val("word1", w1 | 13'h1800, word1_out);
		chk_val("customer", w2, customer_code);
		chk_bit("package_20pin", ~w0[9], package_20pin);
		chk_val("periods", w0[8] ? 3'h4 : 3'h2, instr_osc_periods);
		chk_bit("watchdog_enable", ~w0[7], watchdog_enable);
		chk_bit("ext_rc", o[2:1] == 2'h0, external_rc_mode);
		chk_bit("int_rc", o[2:1] == 2'h1, internal_rc_mode);
		chk_bit("low_xtal", slow_xt, low_freq_crystal_mode);
		chk_bit("high_xtal", o[2] & ~slow_xt, high_freq_crystal_mode);
		chk_bit("port7_bit0_gpio", rc & ~o[0], port7_bit0_gpio);
		chk_bit("port5_bit5_gpio", o[2:1] == 2'h1, port5_bit5_gpio);
		chk_bit("dedicated", ~rc, osc_pins_dedicated);
		chk_bit("power", w0[3], power_level_sel);
		chk_bit("protect", w0[2:0] != 3'h7, code_protect);
		chk_bit("open_drain", rc & o[0] & ~w1[10], osc_out_open_drain);
		chk_bit("instr_clk", rc & o[0] & w1[10], osc_out_instr_clk);
		chk_val("pulse", w1[9] ? 6'h20 : 6'h08, filter_pulse_len);
		chk_bit("filter", w1[8] & ~slow_xt & ~sleep_mode, glitch_filter_active);
		chk_val("wdt", w1[7] ? WL[22:0] : WS[22:0], wdt_timeout_cycles);
		chk_val("pc_cycles", w1[6] ? 2'h2 : 2'h1, pc_write_cycles);
		chk_bit("trim", w1[5:2] == 4'hf, rc_trim_auto);
		chk_val("freq", w1[1] ? (w1[0] ? 14'h0fa0 : 14'h1f40)
			: (w1[0] ? 14'h03e8 : 14'h01c7), rc_freq_khz);
	endtask : check_all

	task automatic end_sim();
		$display("tests_run %0d n_mismatch %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim

	// ======================================================================
	// Tests
	initial begin
		nrst = 1'b0;
		sleep_mode = 1'b0;
		w0 = 13'h1fff;
		w1 = 13'h1fff;
		w2 = 13'h1fff;
		load(13'h1fff, 13'h1fff, 13'h1fff);
		check_all();
		$display("test defaults done");
		// Reserved bits are stored as zero to prove they read back as one.
		for (k = 0; k < 8; k++) begin
			load({3'h0, k[0], k[1], k[2], k[2:0], k[0] ^ k[1], k[2:0]},
				{2'h0, k[0], k[1], ~k[0], k[1] ^ k[2], ~k[1],
				(k == 5) ? 4'he : 4'hf, k[1:0]}, 13'h0a5a ^ k[12:0]);
			check_all();
		end
		$display("test oscillator modes done");
		load(13'h1fff, 13'h1fff, 13'h1234);
		sleep_mode = 1'b1;
		@(negedge clk);
		chk_bit("filter_sleep", 1'b0, glitch_filter_active);
		sleep_mode = 1'b0;
		@(negedge clk);
		chk_bit("filter_wake", 1'b1, glitch_filter_active);
		$display("test sleep bypass done");
		w0 = 13'h0000;
		w1 = 13'h0000;
		w2 = 13'h0000;
		repeat (10) @(negedge clk);
		chk_val("word0_hold", 13'h1fff, word0_out);
		chk_val("customer_hold", 13'h1234, customer_code);
		chk_bit("high_xtal_hold", 1'b1, high_freq_crystal_mode);
		$display("test hold done");
		// A reset that cuts a load short must restart it from word 0.
		nrst = 1'b0;
		@(negedge clk);
		nrst = 1'b1;
		repeat (2) @(negedge clk);
		load(13'h0d24, 13'h0a3e, 13'h0001);
		check_all();
		$display("test aborted load done");
		end_sim();
	end
endmodule : tb_top
